//--- rtl/twsts_pkg.sv
// Constants, field layouts and types for the two-wire slave transmitter status block.
// Assumes one 40 MHz core clock; all software-side strobes come from that clock domain.
//
// Summary of operation
// - Own read address acked posts A8
// - Lost arbitration then read-addressed posts B0
// - Data byte acked posts B8, awaits load
// - Data byte not acked posts C0, unaddress
// - Last byte acked posts C8, unaddress
// - Start request sends START once bus free
// - General call answered only when enabled
// - Flag clear shows status F8
// - START/STOP inside frame posts 00, sets flag
// - Recovery unaddresses, hardware clears stop bit
// - Recovery releases both lines, no STOP
// - Buffer need not hold byte after wake
// - Repeated START restarts address phase, keeps bus
// - Ack-enable cleared makes current byte last
// - Clock held low while flag set, except after a bus error
// - Status code in bits 7 to 3
package twsts_pkg;

  // ***************************************************
  // Status codes, prescaler bits already masked to zero
  // ***************************************************
  localparam logic [7:0] ST_OWN_READ = 8'ha8;
  localparam logic [7:0] ST_ARB_READ = 8'hb0;
  localparam logic [7:0] ST_DATA_ACK = 8'hb8;
  localparam logic [7:0] ST_DATA_NACK = 8'hc0;
  localparam logic [7:0] ST_LAST_ACK = 8'hc8;
  localparam logic [7:0] ST_NO_INFO = 8'hf8;
  localparam logic [7:0] ST_BUS_ERR = 8'h00;

  // ***************************************************
  // Field positions and bus constants
  // ***************************************************
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 3;
  localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT_IDX = 4'h7;

  // ***************************************************
  // Reset values
  // ***************************************************
  localparam logic [6:0] OWN_ADDR_RST = 7'h00;
  localparam logic [1:0] PRESCALE_RST = 2'h0;
  localparam logic [7:0] BUFFER_RST = 8'h00;

  // ***************************************************
  // Timing: START hold before the clock is pulled low
  // ***************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int START_HOLD_NS = 4000;
  localparam int START_HOLD_CYC = (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] START_HOLD_LAST = 8'(START_HOLD_CYC - 1);

  // ***************************************************
  // Types
  // ***************************************************
  // Control bits written and read back by software
  typedef struct packed {
    logic job_done_flag;
    logic ack_enable_bit;
    logic start_request_bit;
    logic stop_request_bit;
  } twsts_ctl_t;

  // Own address plus general call enable
  typedef struct packed {
    logic [6:0] own_slave_address;
    logic general_call_enable;
  } twsts_addr_t;

  // Engine states
  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_WAIT,
    S_TX_LOAD,
    S_TX_BIT,
    S_TX_ACK,
    S_ERROR,
    S_START_GEN,
    S_MASTER
  } twsts_state_t;

endpackage

//--- rtl/twsts_sync.sv
// Two flip-flop synchroniser for one bus line.
// Assumes the line idles high, so both stages reset to one.
`timescale 1ns/1ps
`default_nettype none
module twsts_sync (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg; // First stage, read only by the second

  // ***************************************************
  // Synchroniser chain
  // ***************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_reg <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

//--- rtl/twsts_core.sv
// Slave transmitter status engine for a two-wire serial bus.
// Assumes software strobes are synchronous to core_clk; bus lines are open drain, pulled up outside.
`timescale 1ns/1ps
`default_nettype none
module twsts_core (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ctl_wr,
  input wire twsts_pkg::twsts_ctl_t ctl_wdata,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic addr_wr,
  input wire twsts_pkg::twsts_addr_t addr_wdata,
  input wire logic prescale_wr,
  input wire logic [1:0] prescale_wdata,
  input wire logic arb_lost_sla,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output var twsts_pkg::twsts_ctl_t bus_control,
  output logic [7:0] bus_status,
  output logic [7:0] byte_buffer,
  output var twsts_pkg::twsts_addr_t own_address,
  output logic write_collision,
  output logic start_issued
);
  import twsts_pkg::*;

  // ***************************************************
  // Declarations
  // ***************************************************
  twsts_ctl_t bus_control_reg; // Software control bits
  twsts_addr_t own_address_reg; // Own address and call enable
  twsts_state_t state_reg; // Engine state
  logic [7:0] byte_buffer_reg; // Byte loaded by software
  logic [7:0] shift_reg; // Address in, data out
  logic [7:0] posted_code_reg; // Held status code
  logic [7:0] hold_cnt_reg; // START hold timer
  logic [3:0] bit_cnt_reg; // Bits in current byte
  logic [1:0] prescale_reg; // Rate prescale field
  logic scl_oe_reg, sda_oe_reg; // Line pull-down enables
  logic scl_d_reg, sda_d_reg; // Previous synced levels
  logic read_dir_reg; // Own address with read bit
  logic last_byte_reg; // Byte sent as the last one
  logic ack_seen_reg; // Master acked on ninth clock
  logic arb_lost_reg; // Lost arbitration this frame
  logic bus_busy_reg; // Between START and STOP
  logic wcol_reg, start_issued_reg;
  logic scl_s, sda_s; // Synchronised lines
  logic scl_rise, scl_fall, start_det, stop_det;
  logic in_frame, bus_err, addr_hit, own_hit;
  logic clear_ok, recover_ok, post_now, tx_code;

  // ***************************************************
  // Line sampling and condition detection
  // ***************************************************
  twsts_sync u_scl_sync (.core_clk(core_clk), .srst(srst), .async_in(scl_i), .sync_out(scl_s));
  twsts_sync u_sda_sync (.core_clk(core_clk), .srst(srst), .async_in(sda_i), .sync_out(sda_s));

  // Previous levels for edge finding
  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  // Data moves while clock stays high: START falls, STOP rises
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Bus occupancy, used to wait for a free bus
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_busy_reg <= 1'b0;
    end else if (start_det) begin
      bus_busy_reg <= 1'b1;
    end else if (stop_det) begin
      bus_busy_reg <= 1'b0;
    end
  end

  // ***************************************************
  // Decodes
  // ***************************************************
  // A START at bit 0 of the address is a legal restart, not an error
  assign in_frame = (state_reg == S_ADDR && bit_cnt_reg != 4'h0) || state_reg == S_ADDR_ACK ||
                    state_reg == S_TX_LOAD || state_reg == S_TX_BIT || state_reg == S_TX_ACK;
  assign bus_err = in_frame & (start_det | stop_det);
  assign own_hit = shift_reg[7:1] == own_address_reg.own_slave_address;
  // Address recognised only with ack enabled; call address needs its enable
  assign addr_hit = bus_control_reg.ack_enable_bit & (own_hit |
                    (shift_reg[7:1] == GENERAL_CALL_ADDRESS & own_address_reg.general_call_enable));
  // Flag clear honoured while waiting, or with stop for recovery
  assign clear_ok = ctl_wr & ctl_wdata.job_done_flag & (state_reg == S_WAIT | ctl_wdata.stop_request_bit);
  assign recover_ok = ctl_wr & ctl_wdata.job_done_flag & ctl_wdata.stop_request_bit &
                      (state_reg == S_ERROR | state_reg == S_MASTER);
  assign post_now = bus_err | (state_reg == S_ADDR_ACK & scl_fall & read_dir_reg) |
                    (state_reg == S_TX_ACK & scl_fall);
  assign tx_code = posted_code_reg == ST_OWN_READ | posted_code_reg == ST_ARB_READ |
                   posted_code_reg == ST_DATA_ACK;

  // ***************************************************
  // Control register
  // ***************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_control_reg <= '0;
    end else begin
      if (ctl_wr) begin
        bus_control_reg.ack_enable_bit <= ctl_wdata.ack_enable_bit;
        bus_control_reg.start_request_bit <= ctl_wdata.start_request_bit;
        bus_control_reg.stop_request_bit <= ctl_wdata.stop_request_bit;
      end
      // Hardware clears only the stop bit on recovery
      if (recover_ok) begin
        bus_control_reg.stop_request_bit <= 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (post_now) begin
        bus_control_reg.job_done_flag <= 1'b1;
      end else if (clear_ok) begin
        bus_control_reg.job_done_flag <= 1'b0;
      end
    end
  end

  // ***************************************************
  // Data buffer, address and prescale
  // ***************************************************
  // Buffer is written only while the flag is up; contents after wake are not trusted
  always_ff @(posedge core_clk) begin
    if (srst) begin
      byte_buffer_reg <= BUFFER_RST;
      wcol_reg <= 1'b0;
    end else if (data_wr) begin
      if (bus_control_reg.job_done_flag) begin
        byte_buffer_reg <= data_wdata;
        wcol_reg <= 1'b0;
      end else begin
        wcol_reg <= 1'b1;
      end
    end
  end

  // Own address and prescale storage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      own_address_reg <= {OWN_ADDR_RST, 1'b0};
      prescale_reg <= PRESCALE_RST;
    end else begin
      if (addr_wr) begin
        own_address_reg <= addr_wdata;
      end
      if (prescale_wr) begin
        prescale_reg <= prescale_wdata;
      end
    end
  end

  // Lost arbitration is remembered until the next status is posted
  always_ff @(posedge core_clk) begin
    if (srst) begin
      arb_lost_reg <= 1'b0;
    end else if (arb_lost_sla) begin
      arb_lost_reg <= 1'b1;
    end else if (post_now) begin
      arb_lost_reg <= 1'b0;
    end
  end

  // ***************************************************
  // Transfer engine
  // ***************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= S_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      posted_code_reg <= ST_NO_INFO;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      read_dir_reg <= 1'b0;
      last_byte_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      hold_cnt_reg <= 8'h00;
      start_issued_reg <= 1'b0;
    end else begin
      start_issued_reg <= 1'b0;
      if (bus_err) begin
        // Error: post code, let go of both lines
        state_reg <= S_ERROR;
        posted_code_reg <= ST_BUS_ERR;
        scl_oe_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          S_IDLE: begin
            // Any START, repeated ones included, opens an address phase
            if (start_det) begin
              state_reg <= S_ADDR;
              bit_cnt_reg <= 4'h0;
            end else if (bus_control_reg.start_request_bit & ~bus_busy_reg &
                         ~bus_control_reg.job_done_flag) begin
              state_reg <= S_START_GEN;
              sda_oe_reg <= 1'b1;
              hold_cnt_reg <= 8'h00;
            end
          end
          S_ADDR: begin
            if (start_det) begin
              bit_cnt_reg <= 4'h0;
            end else if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
              if (addr_hit) begin
                state_reg <= S_ADDR_ACK;
                sda_oe_reg <= 1'b1;
                read_dir_reg <= own_hit & shift_reg[0];
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_ADDR_ACK: begin
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              if (read_dir_reg) begin
                state_reg <= S_WAIT;
                scl_oe_reg <= 1'b1;
                posted_code_reg <= arb_lost_reg ? ST_ARB_READ : ST_OWN_READ;
              end else begin
                // Write direction belongs to the receiver side
                state_reg <= S_IDLE;
              end
            end
          end
          S_WAIT: begin
            // Code and clock stretch hold until the flag is cleared
            if (clear_ok) begin
              if (tx_code) begin
                state_reg <= S_TX_LOAD;
                shift_reg <= byte_buffer_reg;
                sda_oe_reg <= ~byte_buffer_reg[7];
                last_byte_reg <= ~ctl_wdata.ack_enable_bit;
                bit_cnt_reg <= 4'h0;
              end else begin
                // After C0 or C8: not addressed, recognition per ack enable
                state_reg <= S_IDLE;
                scl_oe_reg <= 1'b0;
              end
            end
          end
          S_TX_LOAD: begin
            // One cycle of data setup before the clock is let go
            state_reg <= S_TX_BIT;
            scl_oe_reg <= 1'b0;
          end
          S_TX_BIT: begin
            if (scl_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == LAST_BIT_IDX) begin
                state_reg <= S_TX_ACK;
                sda_oe_reg <= 1'b0;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_oe_reg <= ~shift_reg[6];
              end
            end
          end
          S_TX_ACK: begin
            if (scl_rise) begin
              ack_seen_reg <= ~sda_s;
            end else if (scl_fall) begin
              state_reg <= S_WAIT;
              scl_oe_reg <= 1'b1;
              if (!ack_seen_reg) begin
                posted_code_reg <= ST_DATA_NACK;
              end else if (last_byte_reg) begin
                posted_code_reg <= ST_LAST_ACK;
              end else begin
                posted_code_reg <= ST_DATA_ACK;
              end
            end
          end
          S_START_GEN: begin
            // Data held low with clock high, then the clock follows
            hold_cnt_reg <= hold_cnt_reg + 8'h01;
            if (hold_cnt_reg == START_HOLD_LAST) begin
              state_reg <= S_MASTER;
              scl_oe_reg <= 1'b1;
              start_issued_reg <= 1'b1;
            end
          end
          S_MASTER, S_ERROR: begin
            // Leave quietly: lines released, no STOP driven
            if (recover_ok) begin
              state_reg <= S_IDLE;
              scl_oe_reg <= 1'b0;
              sda_oe_reg <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;
  assign bus_control = bus_control_reg;
  assign byte_buffer = byte_buffer_reg;
  assign own_address = own_address_reg;
  assign write_collision = wcol_reg;
  assign start_issued = start_issued_reg;
  // No information while the flag is down
  assign bus_status = {(bus_control_reg.job_done_flag ? posted_code_reg[CODE_MSB:CODE_LSB]
                        : ST_NO_INFO[CODE_MSB:CODE_LSB]), 1'b0, prescale_reg};

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_no_info_idle: assert property (!bus_control_reg.job_done_flag |-> bus_status[7:3] == 5'h1f)
    else $error("status not F8 with flag clear");
  a_error_posts_zero: assert property (bus_err |=> bus_control_reg.job_done_flag && bus_status[7:3] == 5'h00)
    else $error("bus error not posted as 00");
  a_recover_release: assert property (recover_ok |=> !bus_control_reg.stop_request_bit && state_reg == S_IDLE
    && !scl_oe && !sda_oe)
    else $error("recovery did not release and clear stop");
  a_stretch_clock: assert property (state_reg == S_WAIT |-> scl_oe && bus_control_reg.job_done_flag)
    else $error("clock not held while flag set");
  a_code_stable: assert property (bus_control_reg.job_done_flag && $past(bus_control_reg.job_done_flag)
    |-> $stable(posted_code_reg))
    else $error("posted code changed while flag set");
  a_nack_code: assert property (state_reg == S_TX_ACK && scl_fall && !ack_seen_reg |=> bus_status[7:3] == 5'h18)
    else $error("nack not posted as C0");
  a_ack_code: assert property (state_reg == S_TX_ACK && scl_fall && ack_seen_reg
    |=> bus_status[7:3] == (last_byte_reg ? 5'h19 : 5'h17))
    else $error("ack code wrong for byte kind");
  a_read_addr_code: assert property (state_reg == S_ADDR_ACK && scl_fall && read_dir_reg
    |=> bus_status[7:3] == 5'h15 || bus_status[7:3] == 5'h16)
    else $error("read address not posted as A8 or B0");
  a_msb_first: assert property (state_reg == S_TX_LOAD |-> sda_oe == !shift_reg[7] ##1 !scl_oe)
    else $error("first bit not MSB or clock kept");
  a_start_shape: assert property (state_reg == S_START_GEN |-> sda_oe && !scl_oe)
    else $error("START not driven data-first");

  c_own_read: cover property (state_reg == S_WAIT && posted_code_reg == ST_OWN_READ);
  c_data_nack: cover property (state_reg == S_WAIT && posted_code_reg == ST_DATA_NACK);
  c_last_ack: cover property (state_reg == S_WAIT && posted_code_reg == ST_LAST_ACK);
  c_bus_error: cover property (bus_err);
  c_start_sent: cover property (start_issued_reg);
endmodule
`default_nettype wire

//--- tb/twsts_master_model.sv
// Behavioural two-wire bus master acting as receiver, called by the bench.
// Assumes open-drain lines pulled up in the bench; an output high pulls its line low.
`timescale 1ns/1ps
`default_nettype none
module twsts_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_lo,
  output logic sda_lo
);
  // ****************************************
  // Bit level
  // ****************************************
  // Lines released at time zero
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end

  // Low phase long, so a slave stretch lands before our release
  task automatic bit_out(input logic b);
    sda_lo = !b;
    #100;
    scl_lo = 1'b0;
    wait (scl === 1'b1);
    #100;
    scl_lo = 1'b1;
    #50;
  endtask

  // Sample in mid high phase; sda released beforehand
  task automatic bit_in(output logic b);
    sda_lo = 1'b0;
    #100;
    scl_lo = 1'b0;
    wait (scl === 1'b1);
    #50;
    b = sda;
    #50;
    scl_lo = 1'b1;
    #50;
  endtask

  // START from idle, or repeated START from a low clock
  task automatic start;
    sda_lo = 1'b0;
    #50;
    scl_lo = 1'b0;
    wait (scl === 1'b1);
    #100;
    sda_lo = 1'b1;
    #100;
    scl_lo = 1'b1;
    #50;
  endtask

  // STOP leaves both lines released
  task automatic stop;
    sda_lo = 1'b1;
    #100;
    scl_lo = 1'b0;
    wait (scl === 1'b1);
    #100;
    sda_lo = 1'b0;
    #200;
  endtask

  // ****************************************
  // Byte level, MSB first, ack on ninth clock
  // ****************************************
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    bit_in(ack);
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_in(b[i]);
    bit_out(!ack);
  endtask
endmodule
`default_nettype wire

//--- tb/two_wire_slave_tx_status_tb.sv
// Self-checking bench for the slave transmitter status engine.
// Assumes the master model on the wires; software strobes change 2 ns after the clock edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
module two_wire_slave_tx_status_tb;
  import twsts_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic ctl_wr = 1'b0, data_wr = 1'b0, addr_wr = 1'b0, prescale_wr = 1'b0, arb_lost_sla = 1'b0;
  twsts_ctl_t ctl_wdata = '0;
  twsts_addr_t addr_wdata = '0;
  logic [7:0] data_wdata = 8'h00;
  logic [1:0] prescale_wdata = 2'h3;
  logic scl, sda, scl_o, sda_o, scl_oe, sda_oe, m_scl, m_sda, ack;
  twsts_ctl_t bus_control;
  twsts_addr_t own_address;
  logic [7:0] bus_status, byte_buffer, rb;
  logic start_issued, wcol; // START done pulse, write collision level
  int n_errors = 0, n_tests = 0, cyc = 0;
  // Wired-AND of open-drain parties, pulled up
  assign scl = !(scl_oe || m_scl);
  assign sda = !(sda_oe || m_sda);
  always #12.5 core_clk = ~core_clk;
  twsts_core i_dut (.core_clk(core_clk), .srst(srst), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .data_wr(data_wr), .data_wdata(data_wdata), .addr_wr(addr_wr), .addr_wdata(addr_wdata),
    .prescale_wr(prescale_wr), .prescale_wdata(prescale_wdata), .arb_lost_sla(arb_lost_sla),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .bus_control(bus_control), .bus_status(bus_status), .byte_buffer(byte_buffer),
    .own_address(own_address), .write_collision(wcol), .start_issued(start_issued));
  twsts_master_model i_mst (.scl(scl), .sda(sda), .scl_lo(m_scl), .sda_lo(m_sda));
  // ****************************************
  // Tasks
  // ****************************************
  // Verdict and end of run
  task automatic results;
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard, well above the expected run of about 1500 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  // Strobes last one cycle; an extra edge lets readbacks land
  task automatic sw_ctl(input twsts_ctl_t v);
    @(posedge core_clk);
    #2;
    ctl_wdata = v;
    ctl_wr = 1'b1;
    @(posedge core_clk);
    #2;
    ctl_wr = 1'b0;
    @(posedge core_clk);
    #2;
  endtask
  task automatic sw_misc(input twsts_addr_t a, input logic [7:0] d, input logic arb);
    @(posedge core_clk);
    #2;
    addr_wdata = a;
    data_wdata = d;
    addr_wr = 1'b1;
    data_wr = 1'b1;
    prescale_wr = 1'b1;
    arb_lost_sla = arb;
    @(posedge core_clk);
    #2;
    {addr_wr, data_wr, prescale_wr, arb_lost_sla} = 4'h0;
  endtask
  // Bounded wait for the flag
  task automatic wait_flag;
    for (int i = 0; i < 3000 && bus_control.job_done_flag !== 1'b1; i++) begin
      @(posedge core_clk);
      #2;
    end
  endtask
  // Posted code held with clock stretched, then load and clear
  task automatic serve(input logic [7:0] code, input logic [7:0] d, input twsts_ctl_t c);
    wait_flag();
    repeat (5) @(posedge core_clk);
    #2;
    `CHK(bus_status, code | 8'h03)
    `CHK(scl, 1'b0)
    sw_misc({7'h2a, 1'b1}, d, 1'b0);
    `CHK({byte_buffer, wcol}, {d, 1'b0})
    sw_ctl(c);
  endtask
  // Address phase towards our slave
  task automatic address(input logic [7:0] a);
    i_mst.start();
    i_mst.wr_byte(a, ack);
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (3) @(posedge core_clk);
    #2;
    srst = 1'b0;
    `CHK(bus_status, ST_NO_INFO)
    `CHK(bus_control, 4'h0)
    sw_misc({7'h2a, 1'b0}, 8'h00, 1'b0);
    `CHK({wcol, own_address}, {1'b1, 8'h54})
    sw_ctl(4'b0100);
    `CHK(bus_status, 8'hfb)
    // Read, continue, last byte, then master over-reads
    address({7'h2a, 1'b1});
    `CHK(ack, 1'b0)
    serve(ST_OWN_READ, 8'ha5, 4'b1100);
    i_mst.rd_byte(1'b1, rb);
    `CHK(rb, 8'ha5)
    serve(ST_DATA_ACK, 8'h3c, 4'b1000);
    i_mst.rd_byte(1'b1, rb);
    `CHK(rb, 8'h3c)
    serve(ST_LAST_ACK, 8'h00, 4'b1100);
    i_mst.rd_byte(1'b0, rb);
    `CHK(rb, 8'hff)
    i_mst.stop();
    // Lost arbitration entry, nack, then ack disabled
    // Write address, then repeated START turns the transfer to a read
    sw_misc({7'h2a, 1'b0}, 8'h00, 1'b1);
    address({7'h2a, 1'b0});
    `CHK(ack, 1'b0)
    address({7'h2a, 1'b1});
    serve(ST_ARB_READ, 8'h81, 4'b1100);
    i_mst.rd_byte(1'b0, rb);
    `CHK(rb, 8'h81)
    serve(ST_DATA_NACK, 8'h00, 4'b1000);
    i_mst.stop();
    address({7'h2a, 1'b1});
    `CHK(ack, 1'b1)
    `CHK(bus_status, 8'hfb)
    i_mst.stop();
    // General call off, then on
    sw_ctl(4'b0100);
    sw_misc({7'h2a, 1'b0}, 8'h00, 1'b0);
    address(8'h00);
    `CHK(ack, 1'b1)
    i_mst.stop();
    sw_misc({7'h2a, 1'b1}, 8'h00, 1'b0);
    address(8'h00);
    `CHK(ack, 1'b0)
    i_mst.stop();
    // START inside a data byte, then recovery
    address({7'h2a, 1'b1});
    serve(ST_OWN_READ, 8'hff, 4'b1100);
    i_mst.bit_in(ack);
    i_mst.bit_in(ack);
    i_mst.start();
    wait_flag();
    `CHK(bus_status, ST_BUS_ERR | 8'h03)
    `CHK({scl_oe, sda_oe}, 2'b00)
    sw_ctl(4'b1101);
    `CHK(bus_control, 4'b0100)
    `CHK({bus_status, sda_oe}, {8'hfb, 1'b0})
    i_mst.stop();
    // START request on a free bus
    sw_ctl(4'b0110);
    for (int i = 0; i < 400 && start_issued !== 1'b1; i++) begin
      @(posedge core_clk);
      #2;
    end
    `CHK({start_issued, scl, sda}, 3'b100)
    sw_ctl(4'b1101);
    `CHK({scl_o, sda_o, scl_oe, sda_oe}, 4'h0)
    results();
  end
endmodule
`default_nettype wire
